// [crf_record_framer.v]
`timescale 1ns/1ps
`include "crf_defines.vh"
// Notes on behaviour
// - blocked record opens with 32 sync 0x16
// - one start-of-text 0x02 follows sync
// - length byte then that many payload bytes
// - end-of-text 0x03 after last payload byte
// - two-byte check: payload sum plus 255
// - error flag clear on success, code on failure
// - only reads detect errors
// - read error codes one to six
// - tape bits and status at port 0xfc
// - dump/load as blocked records, stop on error
// - filler characters before dump; load ignores
// - lamps: address, blank on success, flash error
// - test write repeats filler character forever
// - test read shows unaligned received bytes
// - one stop bit, always zero
// - eight data bits, lsb first
// - 6 ms frame: 2 kHz burst then silence
// - short burst zero, long burst one
// - sync hunt needs no stop bit
module crf_record_framer #(
	parameter [23:0] FRAME_CYC = `CRF_FRAME_US * `CRF_CLK_MHZ,
	parameter [23:0] HALF_CYC = `CRF_TONE_HALF_US * `CRF_CLK_MHZ,
	parameter [23:0] ZERO_CYC = `CRF_ZERO_TONE_US * `CRF_CLK_MHZ,
	parameter [23:0] ONE_CYC = `CRF_ONE_TONE_US * `CRF_CLK_MHZ,
	parameter [27:0] HUNT_CYC = `CRF_HUNT_MS * `CRF_CLK_MHZ * 1000,
	parameter [27:0] FLASH_CYC = `CRF_FLASH_MS * `CRF_CLK_MHZ * 1000,
	parameter [7:0] INIT_CHAR = 8'haa
) (
	input wire clk_sys, // system clock
	input wire reset_n, // async reset
	input wire wb_cyc_i, // bus cycle
	input wire wb_stb_i, // strobe
	input wire wb_we_i, // write enable
	input wire [7:0] wb_adr_i, // byte address
	input wire [3:0] wb_sel_i, // byte lanes
	input wire [31:0] wb_dat_i, // write data
	output reg [31:0] wb_dat_o, // read data
	output reg wb_ack_o, // acknowledge
	output wire [15:0] mem_addr, // memory address
	output wire mem_rd, // memory read request
	output reg mem_wr, // memory write pulse
	output reg [7:0] mem_wdata, // memory write data
	input wire [7:0] mem_rdata, // memory data, one cycle after address
	output wire [1:0] tape_code, // tape output bits
	input wire tone_in, // tone detector status
	output reg [7:0] operator_lamp_byte // display lamps
);
	localparam integer FILL_N = (`CRF_FILL_MS * 1000 + 9 * `CRF_FRAME_US - 1) / (9 * `CRF_FRAME_US);
	localparam [7:0] FILL_CHARS = FILL_N[7:0];
	localparam [20:0] S_IDLE = 21'h000001;
	localparam [20:0] S_START = 21'h000002;
	localparam [20:0] S_FILL = 21'h000004;
	localparam [20:0] S_WSYNC = 21'h000008;
	localparam [20:0] S_WSTX = 21'h000010;
	localparam [20:0] S_WLEN = 21'h000020;
	localparam [20:0] S_WDATA = 21'h000040;
	localparam [20:0] S_WETX = 21'h000080;
	localparam [20:0] S_WCKL = 21'h000100;
	localparam [20:0] S_WCKH = 21'h000200;
	localparam [20:0] S_WEND = 21'h000400;
	localparam [20:0] S_TONE_TEST_WRITE = 21'h000800;
	localparam [20:0] S_RHUNT = 21'h001000;
	localparam [20:0] S_RSYNC = 21'h002000;
	localparam [20:0] S_RLEN = 21'h004000;
	localparam [20:0] S_RDATA = 21'h008000;
	localparam [20:0] S_RETX = 21'h010000;
	localparam [20:0] S_RCKL = 21'h020000;
	localparam [20:0] S_RCKH = 21'h040000;
	localparam [20:0] S_TONE_TEST_READ = 21'h080000;
	localparam [20:0] S_DONE = 21'h100000;
	localparam [20:0] TX_STATES = S_FILL | S_WSYNC | S_WSTX | S_WLEN | S_WDATA | S_WETX | S_WCKL | S_WCKH | S_TONE_TEST_WRITE;
	reg [7:0] status_r;
	reg [7:0] length_r;
	reg [15:0] addr_r;
	reg [7:0] switch_r;
	reg [20:0] state_r;
	reg op_dir_r;
	reg op_blk_r;
	reg [7:0] op_len_r;
	reg [7:0] cnt_r;
	reg [15:0] cur_addr_r;
	reg [15:0] sum_r;
	reg [7:0] ck_lo_r;
	reg fail_r;
	reg err_flag_r;
	reg [2:0] code_r;
	reg dl_r;
	reg [3:0] blk_r;
	reg [5:0] rec_r;
	reg [27:0] tmr_r;
	reg settle_r;
	reg flashing_r;
	reg flash_on_r;
	reg [1:0] rx_mode;
	reg [7:0] tx_byte;
	wire tx_ready;
	wire tx_go;
	wire rx_valid;
	wire [7:0] rx_byte;
	wire tone_level;
	wire busy = state_r != S_IDLE;
	wire req = wb_cyc_i & wb_stb_i;
	wire wr_en = req & wb_we_i & wb_ack_o;
	wire cmd_go = wr_en & (wb_adr_i == `CRF_REG_CMD) & wb_sel_i[0];
	wire [2:0] cmd = wb_dat_i[2:0];
	crf_byte_codec #(
		.FRAME_CYC(FRAME_CYC),
		.HALF_CYC(HALF_CYC),
		.ZERO_CYC(ZERO_CYC),
		.ONE_CYC(ONE_CYC)
	) u_codec (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.tx_go(tx_go),
		.tx_byte(tx_byte),
		.tx_ready(tx_ready),
		.tape_code(tape_code),
		.tone_in(tone_in),
		.tone_level(tone_level),
		.rx_mode(rx_mode),
		.rx_valid(rx_valid),
		.rx_byte(rx_byte)
	);
	assign mem_addr = cur_addr_r;
	assign mem_rd = state_r == S_WDATA;
	// wait one cycle after an address change before sending memory data
	assign tx_go = tx_ready & ((state_r & TX_STATES) != 21'h000000) & ((state_r != S_WDATA) | settle_r);
	always @* begin
		case (state_r)
			S_WSYNC: tx_byte = `CRF_SYNC_CHAR;
			S_WSTX: tx_byte = `CRF_STX_CHAR;
			S_WLEN: tx_byte = op_len_r;
			S_WDATA: tx_byte = mem_rdata;
			S_WETX: tx_byte = `CRF_ETX_CHAR;
			S_WCKL: tx_byte = sum_r[7:0];
			S_WCKH: tx_byte = sum_r[15:8];
			default: tx_byte = INIT_CHAR;
		endcase
		case (state_r)
			S_RHUNT: rx_mode = `CRF_RX_HUNT;
			S_RSYNC, S_RLEN, S_RDATA, S_RETX, S_RCKL, S_RCKH: rx_mode = `CRF_RX_FRAMED;
			S_TONE_TEST_READ: rx_mode = `CRF_RX_RAW;
			default: rx_mode = `CRF_RX_OFF;
		endcase
	end
	// bus slave: ack one cycle after the request, write at the ack edge
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
			status_r <= `CRF_RST_STATUS;
			length_r <= `CRF_RST_LENGTH;
			addr_r <= `CRF_RST_ADDR;
			switch_r <= `CRF_RST_SWITCH;
		end else begin
			wb_ack_o <= req & ~wb_ack_o;
			if (req && !wb_ack_o) begin
				case (wb_adr_i)
					`CRF_REG_STATUS: wb_dat_o <= {24'h000000, status_r};
					`CRF_REG_LENGTH: wb_dat_o <= {24'h000000, length_r};
					`CRF_REG_ADDR: wb_dat_o <= {16'h0000, addr_r};
					`CRF_REG_RESULT: wb_dat_o <= {21'h000000, code_r, 6'h00, err_flag_r, busy};
					`CRF_REG_SWITCH: wb_dat_o <= {24'h000000, switch_r};
					`CRF_REG_LAMP: wb_dat_o <= {24'h000000, operator_lamp_byte};
					`CRF_REG_PANEL: wb_dat_o <= {29'h00000000, tape_code, tone_level};
					default: wb_dat_o <= 32'h00000000;
				endcase
			end
			if (wr_en && wb_sel_i[0]) begin
				case (wb_adr_i)
					`CRF_REG_STATUS: status_r <= wb_dat_i[7:0];
					`CRF_REG_LENGTH: length_r <= wb_dat_i[7:0];
					`CRF_REG_ADDR: addr_r[7:0] <= wb_dat_i[7:0];
					`CRF_REG_SWITCH: switch_r <= wb_dat_i[7:0];
					default: ;
				endcase
			end
			if (wr_en && wb_sel_i[1] && wb_adr_i == `CRF_REG_ADDR)
				addr_r[15:8] <= wb_dat_i[15:8];
		end
	end
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= S_IDLE;
			op_dir_r <= 1'b0;
			op_blk_r <= 1'b0;
			op_len_r <= 8'h00;
			cnt_r <= 8'h00;
			cur_addr_r <= 16'h0000;
			sum_r <= `CRF_CKSUM_SEED;
			ck_lo_r <= 8'h00;
			fail_r <= 1'b0;
			err_flag_r <= 1'b0;
			code_r <= 3'h0;
			dl_r <= 1'b0;
			blk_r <= 4'h0;
			rec_r <= 6'h00;
			tmr_r <= 28'h0000000;
			settle_r <= 1'b0;
			flashing_r <= 1'b0;
			flash_on_r <= 1'b0;
			mem_wr <= 1'b0;
			mem_wdata <= 8'h00;
			operator_lamp_byte <= 8'h00;
		end else begin
			mem_wr <= 1'b0;
			settle_r <= (state_r == S_WDATA) & ~tx_go;
			if (mem_wr)
				cur_addr_r <= cur_addr_r + 16'h0001;
			if (dl_r && busy)
				operator_lamp_byte <= cur_addr_r[15:8];
			if (flashing_r) begin
				if (tmr_r == FLASH_CYC) begin
					tmr_r <= 28'h0000000;
					flash_on_r <= ~flash_on_r;
					operator_lamp_byte <= flash_on_r ? 8'h00 : {5'h00, code_r};
				end else
					tmr_r <= tmr_r + 28'h0000001;
			end
			if (cmd_go) begin
				flashing_r <= 1'b0;
				fail_r <= 1'b0;
				code_r <= 3'h0;
				tmr_r <= 28'h0000000;
				operator_lamp_byte <= 8'h00;
				dl_r <= (cmd == `CRF_CMD_DUMP) | (cmd == `CRF_CMD_LOAD);
				blk_r <= switch_r[3:0];
				rec_r <= `CRF_RECS_PER_BLK;
				case (cmd)
					`CRF_CMD_RECORD: begin
						op_dir_r <= status_r[`CRF_DIR_BIT];
						op_blk_r <= status_r[`CRF_BLK_BIT];
						op_len_r <= length_r;
						cur_addr_r <= addr_r;
						state_r <= S_START;
					end
					`CRF_CMD_DUMP, `CRF_CMD_LOAD: begin
						op_dir_r <= cmd == `CRF_CMD_LOAD;
						op_blk_r <= 1'b1;
						op_len_r <= `CRF_REC_LEN;
						cur_addr_r <= {switch_r[7:4], 12'h000};
						cnt_r <= FILL_CHARS;
						if (switch_r[3:0] == 4'h0)
							state_r <= S_DONE;
						else if (cmd == `CRF_CMD_DUMP)
							state_r <= S_FILL;
						else
							state_r <= S_START;
					end
					`CRF_CMD_TONE_TEST_WRITE: state_r <= S_TONE_TEST_WRITE;
					`CRF_CMD_TONE_TEST_READ: state_r <= S_TONE_TEST_READ;
					default: state_r <= S_IDLE;
				endcase
			end else begin
				case (state_r)
					S_IDLE: ;
					S_START: begin
						sum_r <= `CRF_CKSUM_SEED;
						tmr_r <= 28'h0000000;
						cnt_r <= op_blk_r ? (op_dir_r ? 8'h00 : `CRF_SYNC_RUN) : op_len_r;
						if (op_blk_r)
							state_r <= op_dir_r ? S_RHUNT : S_WSYNC;
						else if (op_len_r == 8'h00)
							state_r <= S_WEND;
						else
							state_r <= op_dir_r ? S_RDATA : S_WDATA;
					end
					S_FILL: if (tx_go) begin
						cnt_r <= cnt_r - 8'h01;
						if (cnt_r == 8'h01)
							state_r <= S_START;
					end
					S_WSYNC: if (tx_go) begin
						cnt_r <= cnt_r - 8'h01;
						if (cnt_r == 8'h01)
							state_r <= S_WSTX;
					end
					S_WSTX: if (tx_go)
						state_r <= S_WLEN;
					S_WLEN: if (tx_go) begin
						cnt_r <= op_len_r;
						state_r <= (op_len_r == 8'h00) ? S_WETX : S_WDATA;
					end
					S_WDATA: if (tx_go) begin
						cur_addr_r <= cur_addr_r + 16'h0001;
						sum_r <= sum_r + {8'h00, mem_rdata};
						cnt_r <= cnt_r - 8'h01;
						if (cnt_r == 8'h01)
							state_r <= op_blk_r ? S_WETX : S_WEND;
					end
					S_WETX: if (tx_go)
						state_r <= S_WCKL;
					S_WCKL: if (tx_go)
						state_r <= S_WCKH;
					S_WCKH: if (tx_go)
						state_r <= S_WEND;
					S_WEND: if (tx_ready)
						state_r <= S_DONE;
					S_TONE_TEST_WRITE: ;
					S_RHUNT: begin
						tmr_r <= tmr_r + 28'h0000001;
						if (rx_valid) begin
							cnt_r <= 8'h01;
							state_r <= S_RSYNC;
						end else if (tmr_r == HUNT_CYC) begin
							fail_r <= 1'b1;
							code_r <= `CRF_ERR_NOSYNC;
							state_r <= S_DONE;
						end
					end
					S_RSYNC: if (rx_valid) begin
						if (rx_byte == `CRF_SYNC_CHAR) begin
							cnt_r <= cnt_r + 8'h01;
							if (cnt_r == `CRF_SYNC_RUN) begin
								fail_r <= 1'b1;
								code_r <= `CRF_ERR_MANYSYNC;
								state_r <= S_DONE;
							end
						end else if (rx_byte == `CRF_STX_CHAR)
							state_r <= S_RLEN;
						else begin
							fail_r <= 1'b1;
							code_r <= `CRF_ERR_NOSTX;
							state_r <= S_DONE;
						end
					end
					S_RLEN: if (rx_valid) begin
						cnt_r <= rx_byte;
						if (rx_byte > op_len_r) begin
							fail_r <= 1'b1;
							code_r <= `CRF_ERR_LONG;
							state_r <= S_DONE;
						end else
							state_r <= (rx_byte == 8'h00) ? S_RETX : S_RDATA;
					end
					S_RDATA: if (rx_valid) begin
						mem_wr <= 1'b1;
						mem_wdata <= rx_byte;
						sum_r <= sum_r + {8'h00, rx_byte};
						cnt_r <= cnt_r - 8'h01;
						if (cnt_r == 8'h01)
							state_r <= op_blk_r ? S_RETX : S_DONE;
					end
					S_RETX: if (rx_valid) begin
						if (rx_byte == `CRF_ETX_CHAR)
							state_r <= S_RCKL;
						else begin
							fail_r <= 1'b1;
							code_r <= `CRF_ERR_NOETX;
							state_r <= S_DONE;
						end
					end
					S_RCKL: if (rx_valid) begin
						ck_lo_r <= rx_byte;
						state_r <= S_RCKH;
					end
					S_RCKH: if (rx_valid) begin
						if ({rx_byte, ck_lo_r} != sum_r) begin
							fail_r <= 1'b1;
							code_r <= `CRF_ERR_CKSUM;
						end
						state_r <= S_DONE;
					end
					S_TONE_TEST_READ: if (rx_valid)
						operator_lamp_byte <= rx_byte;
					S_DONE: begin
						if (!fail_r && dl_r && !(rec_r == 6'h01 && blk_r == 4'h1) && blk_r != 4'h0) begin
							if (rec_r == 6'h01) begin
								rec_r <= `CRF_RECS_PER_BLK;
								blk_r <= blk_r - 4'h1;
							end else
								rec_r <= rec_r - 6'h01;
							state_r <= S_START;
						end else begin
							state_r <= S_IDLE;
							err_flag_r <= fail_r & op_dir_r;
							flashing_r <= dl_r & fail_r;
							operator_lamp_byte <= 8'h00;
							tmr_r <= 28'h0000000;
							dl_r <= 1'b0;
						end
					end
					default: state_r <= S_IDLE;
				endcase
			end
		end
	end
endmodule // crf_record_framer

// [crf_defines.vh]
`ifndef CRF_DEFINES_VH
`define CRF_DEFINES_VH
// register byte offsets
`define CRF_REG_STATUS 8'h00
`define CRF_REG_LENGTH 8'h04
`define CRF_REG_ADDR 8'h08
`define CRF_REG_CMD 8'h0c
`define CRF_REG_RESULT 8'h10
`define CRF_REG_SWITCH 8'h14
`define CRF_REG_LAMP 8'h18
`define CRF_REG_PANEL 8'hfc
// status byte fields
`define CRF_DIR_BIT 0
`define CRF_BLK_BIT 7
// reset values
`define CRF_RST_STATUS 8'h00
`define CRF_RST_LENGTH 8'h00
`define CRF_RST_ADDR 16'h0000
`define CRF_RST_SWITCH 8'h00
// commands
`define CRF_CMD_STOP 3'h0
`define CRF_CMD_RECORD 3'h1
`define CRF_CMD_DUMP 3'h2
`define CRF_CMD_LOAD 3'h3
`define CRF_CMD_TONE_TEST_WRITE 3'h4
`define CRF_CMD_TONE_TEST_READ 3'h5
// record characters
`define CRF_SYNC_CHAR 8'h16
`define CRF_STX_CHAR 8'h02
`define CRF_ETX_CHAR 8'h03
`define CRF_SYNC_RUN 8'h20
`define CRF_CKSUM_SEED 16'h00ff
`define CRF_REC_LEN 8'h80
`define CRF_RECS_PER_BLK 6'h20
// error codes
`define CRF_ERR_NOSYNC 3'h1
`define CRF_ERR_MANYSYNC 3'h2
`define CRF_ERR_NOSTX 3'h3
`define CRF_ERR_NOETX 3'h4
`define CRF_ERR_LONG 3'h5
`define CRF_ERR_CKSUM 3'h6
// timing
`define CRF_CLK_MHZ 50
`define CRF_FRAME_US 6000
`define CRF_TONE_HALF_US 250
`define CRF_ZERO_TONE_US 2000
`define CRF_ONE_TONE_US 4000
`define CRF_FILL_MS 10000
`define CRF_FLASH_MS 250
`define CRF_HUNT_MS 2000
// tape output codes
`define CRF_OUT_HIGH 2'h3
`define CRF_OUT_LOW 2'h0
`define CRF_OUT_SIL 2'h2
// receive modes
`define CRF_RX_OFF 2'h0
`define CRF_RX_HUNT 2'h1
`define CRF_RX_FRAMED 2'h2
`define CRF_RX_RAW 2'h3
`endif

// [crf_byte_codec.v]
`timescale 1ns/1ps
`include "crf_defines.vh"
module crf_byte_codec #(
	parameter [23:0] FRAME_CYC = 24'd300000,
	parameter [23:0] HALF_CYC = 24'd12500,
	parameter [23:0] ZERO_CYC = 24'd100000,
	parameter [23:0] ONE_CYC = 24'd200000
) (
	input wire clk_sys, // system clock
	input wire reset_n, // async reset
	input wire tx_go, // start sending tx_byte
	input wire [7:0] tx_byte, // byte to send
	output wire tx_ready, // serialiser idle
	output reg [1:0] tape_code, // tape output bits
	input wire tone_in, // tone present, async
	output wire tone_level, // synchronised tone status
	input wire [1:0] rx_mode, // receive mode
	output reg rx_valid, // byte received pulse
	output reg [7:0] rx_byte // received byte
);
	localparam [23:0] FRAME_LAST = FRAME_CYC - 24'h000001;
	localparam [23:0] HALF_LAST = HALF_CYC - 24'h000001;
	reg [23:0] fcnt_r;
	reg [23:0] hcnt_r;
	reg [3:0] bidx_r;
	reg [7:0] tsh_r;
	reg tbusy_r;
	reg tlvl_r;
	reg [2:0] ts_r;
	reg [23:0] ton_r;
	reg [23:0] sil_r;
	reg [7:0] rsh_r;
	reg [3:0] rcnt_r;
	reg [1:0] mode_d_r;
	wire tbit = bidx_r[3] ? 1'b0 : tsh_r[bidx_r[2:0]];
	wire [23:0] tone_len = tbit ? ONE_CYC : ZERO_CYC;
	wire rise = ts_r[1] & ~ts_r[2];
	wire decide = (ton_r != 24'h000000) & (rise | (~ts_r[1] & (sil_r == FRAME_CYC)));
	wire dbit = ton_r > sil_r;
	wire [7:0] ins = {dbit, rsh_r[7:1]};
	assign tx_ready = ~tbusy_r;
	assign tone_level = ts_r[1];
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			fcnt_r <= 24'h000000;
			hcnt_r <= 24'h000000;
			bidx_r <= 4'h0;
			tsh_r <= 8'h00;
			tbusy_r <= 1'b0;
			tlvl_r <= 1'b1;
			tape_code <= `CRF_OUT_SIL;
		end else begin
			if (tx_go && !tbusy_r) begin
				tsh_r <= tx_byte;
				bidx_r <= 4'h0;
				fcnt_r <= 24'h000000;
				hcnt_r <= 24'h000000;
				tlvl_r <= 1'b1;
				tbusy_r <= 1'b1;
			end else if (tbusy_r) begin
				if (fcnt_r == FRAME_LAST) begin
					fcnt_r <= 24'h000000;
					hcnt_r <= 24'h000000;
					tlvl_r <= 1'b1;
					if (bidx_r == 4'h8)
						tbusy_r <= 1'b0;
					else
						bidx_r <= bidx_r + 4'h1;
				end else begin
					fcnt_r <= fcnt_r + 24'h000001;
					if (hcnt_r == HALF_LAST) begin
						hcnt_r <= 24'h000000;
						tlvl_r <= ~tlvl_r;
					end else
						hcnt_r <= hcnt_r + 24'h000001;
				end
			end
			// burst of 11/00 then silence 10
			if (tbusy_r && fcnt_r < tone_len)
				tape_code <= tlvl_r ? `CRF_OUT_HIGH : `CRF_OUT_LOW;
			else
				tape_code <= `CRF_OUT_SIL;
		end
	end
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			ts_r <= 3'h0;
			ton_r <= 24'h000000;
			sil_r <= 24'h000000;
			rsh_r <= 8'h00;
			rcnt_r <= 4'h0;
			mode_d_r <= `CRF_RX_OFF;
			rx_valid <= 1'b0;
			rx_byte <= 8'h00;
		end else begin
			ts_r <= {ts_r[1:0], tone_in};
			mode_d_r <= rx_mode;
			rx_valid <= 1'b0;
			// tone and silence timing of the current frame
			if (rise) begin
				ton_r <= 24'h000001;
				sil_r <= 24'h000000;
			end else if (ts_r[1]) begin
				if (ton_r != FRAME_CYC)
					ton_r <= ton_r + 24'h000001;
			end else if (sil_r == FRAME_CYC)
				ton_r <= 24'h000000;
			else
				sil_r <= sil_r + 24'h000001;
			if (rx_mode != mode_d_r) begin
				// a sync found by the hunt still owes its stop bit
				rcnt_r <= (mode_d_r == `CRF_RX_HUNT) ? 4'h9 : 4'h0;
				rsh_r <= 8'h00;
			end else if (decide) begin
				case (rx_mode)
					`CRF_RX_HUNT: begin
						rsh_r <= ins;
						if (ins == `CRF_SYNC_CHAR) begin
							rx_valid <= 1'b1;
							rx_byte <= ins;
						end
					end
					`CRF_RX_FRAMED: begin
						if (rcnt_r == 4'h9) begin
							if (!dbit)
								rcnt_r <= 4'h0;
						end else if (rcnt_r == 4'h8) begin
							if (!dbit) begin
								rx_valid <= 1'b1;
								rx_byte <= rsh_r;
								rcnt_r <= 4'h0;
							end
						end else begin
							rsh_r <= ins;
							rcnt_r <= rcnt_r + 4'h1;
						end
					end
					`CRF_RX_RAW: begin
						rsh_r <= ins;
						if (rcnt_r == 4'h7) begin
							rx_valid <= 1'b1;
							rx_byte <= ins;
							rcnt_r <= 4'h0;
						end else
							rcnt_r <= rcnt_r + 4'h1;
					end
					default: rcnt_r <= 4'h0;
				endcase
			end
		end
	end
endmodule // crf_byte_codec

// [crf_record_framer_monitor.sv]
`timescale 1ns/1ps
module crf_record_framer_monitor #(
	parameter [23:0] FRAME_CYC = 24'd300000,
	parameter [23:0] HALF_CYC = 24'd12500,
	parameter [23:0] ONE_CYC = 24'd200000
) (
	input wire clk_sys, // clock
	input wire reset_n, // reset
	input wire wb_cyc_i, // bus cycle
	input wire wb_stb_i, // strobe
	input wire wb_ack_o, // acknowledge
	input wire [15:0] mem_addr, // memory address
	input wire mem_wr, // memory write
	input wire [1:0] tape_code // tape bits
);
	logic [1:0] prev_r;
	logic [23:0] same_r, tone_r, since_r;
	wire tone = tape_code != 2'h2;
	wire was_tone = prev_r != 2'h2;
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			prev_r <= 2'h2;
			same_r <= 24'h0;
			tone_r <= 24'h0;
			since_r <= 24'hffffff;
		end else begin
			prev_r <= tape_code;
			same_r <= (tape_code == prev_r) ? same_r + 24'h1 : 24'h0;
			tone_r <= tone ? tone_r + 24'h1 : 24'h0;
			if (tone && !was_tone)
				since_r <= 24'h1;
			else if (since_r != 24'hffffff)
				since_r <= since_r + 24'h1;
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_ack;
		##1 wb_ack_o ##1 !wb_ack_o;
	endsequence
	chk_ack_pulse: assert property (s_req |-> s_ack)
		else $error("bus ack not one pulse after request");
	chk_code_legal: assert property (tape_code != 2'h1)
		else $error("illegal tape code");
	chk_half_tone: assert property (tone && was_tone && tape_code != prev_r |-> same_r == HALF_CYC - 24'h1)
		else $error("tone half period wrong");
	chk_burst_max: assert property (!tone && was_tone |-> tone_r <= ONE_CYC)
		else $error("tone burst too long");
	chk_frame_space: assert property (tone && !was_tone |-> since_r >= FRAME_CYC)
		else $error("frame shorter than frame time");
	chk_wr_pulse: assert property (mem_wr |=> !mem_wr)
		else $error("memory write longer than one cycle");
	chk_addr_step: assert property (mem_wr |=> mem_addr == $past(mem_addr) + 16'h1)
		else $error("address did not advance after write");
	chk_rx_silent: assert property (mem_wr |-> tape_code == 2'h2)
		else $error("tone sent while storing read data");
endmodule // crf_record_framer_monitor
bind crf_record_framer crf_record_framer_monitor #(.FRAME_CYC(FRAME_CYC), .HALF_CYC(HALF_CYC),
	.ONE_CYC(ONE_CYC)) u_mon (.clk_sys(clk_sys), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .mem_addr(mem_addr), .mem_wr(mem_wr), .tape_code(tape_code));

// [crf_tape_model.sv]
`timescale 1ns/1ps
module crf_tape_model #(
	parameter [23:0] FRAME_CYC = 24'd24,
	parameter [23:0] ZERO_CYC = 24'd8,
	parameter [23:0] ONE_CYC = 24'd16
) (
	input wire clk_sys, // clock
	input wire reset_n, // reset
	input wire [1:0] tape_code, // recorded signal
	output logic tone_in // played-back tone
);
	logic [7:0] got[$];
	logic [8:0] sh;
	int stop_bad = 0;
	int tcnt, scnt, nb;
	initial tone_in = 1'b0;
	// decode recorded frames, byte start after long silence
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			nb = 0;
			tcnt = 0;
			scnt = 0;
		end else if (tape_code != 2'h2) begin
			tcnt = tcnt + 1;
			scnt = 0;
		end else begin
			if (tcnt != 0) begin
				sh = {tcnt > FRAME_CYC / 2, sh[8:1]};
				nb = nb + 1;
			end
			if (nb == 9) begin
				got.push_back(sh[7:0]);
				stop_bad = stop_bad + sh[8];
				nb = 0;
			end
			tcnt = 0;
			scnt = scnt + 1;
			if (scnt > 2 * FRAME_CYC)
				nb = 0;
		end
	end
	task play(input logic [7:0] q[$]);
		logic [8:0] f;
		foreach (q[i]) begin
			f = {1'b0, q[i]};
			for (int b = 0; b < 9; b++) begin
				for (int c = 0; c < FRAME_CYC; c++) begin
					@(posedge clk_sys);
					tone_in <= c < (f[b] ? ONE_CYC : ZERO_CYC);
				end
			end
		end
	endtask
endmodule // crf_tape_model

// [crf_record_framer_tb.sv]
`timescale 1ns/1ps
`include "crf_defines.vh"
module crf_record_framer_tb;
	localparam [23:0] FR = 24'd24;
	localparam logic [7:0] RA[9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'hfc, 8'h20};
	localparam int NS[7] = '{32, 33, 32, 32, 32, 32, 0};
	localparam logic [7:0] SX[7] = '{8'h02, 8'h02, 8'h55, 8'h02, 8'h02, 8'h02, 8'h02};
	localparam int LN[7] = '{2, 2, 2, 3, 2, 2, 2};
	localparam logic [7:0] EX[7] = '{8'h03, 8'h03, 8'h03, 8'h03, 8'h04, 8'h03, 8'h03};
	localparam logic [2:0] EC[7] = '{3'h0, 3'h2, 3'h3, 3'h5, 3'h4, 3'h6, 3'h1};
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'hf;
	logic [3:0] sel = 4'hf;
	logic [31:0] wb_dat_i = 32'h0;
	logic [7:0] mem_rdata = 8'h00;
	logic [31:0] wb_dat_o, q;
	logic wb_ack_o, mem_rd, mem_wr, tone_in;
	logic [15:0] mem_addr;
	logic [7:0] mem_wdata, operator_lamp_byte;
	logic [1:0] tape_code;
	logic [7:0] mem[0:255];
	logic [7:0] pl[$];
	int n_mismatch = 0;
	int checked = 0;
	always #10 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		mem_rdata <= (mem_rd === 1'b1) ? mem[mem_addr[7:0]] : 8'h00;
		if (mem_wr === 1'b1)
			mem[mem_addr[7:0]] <= mem_wdata;
	end
	crf_record_framer #(.FRAME_CYC(FR), .HALF_CYC(24'd2), .ZERO_CYC(24'd8), .ONE_CYC(24'd16),
		.HUNT_CYC(28'd2000), .FLASH_CYC(28'd50)) u_crf_record_framer (
		.clk_sys(clk_sys), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mem_addr(mem_addr), .mem_rd(mem_rd),
		.mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .tape_code(tape_code),
		.tone_in(tone_in), .operator_lamp_byte(operator_lamp_byte));
	crf_tape_model u_crf_tape_model (
		.clk_sys(clk_sys), .reset_n(reset_n), .tape_code(tape_code), .tone_in(tone_in));
	task stop_test;
		$display("mismatches %0d checks %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= sel;
		do begin
			@(posedge clk_sys);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 100);
		if (wb_ack_o !== 1'b1)
			n_mismatch++;
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		check(q, e);
	endtask
	task idle;
		int n;
		n = 0;
		do begin
			wb(1'b0, `CRF_REG_RESULT, 32'h0);
			n++;
		end while (q[0] !== 1'b0 && n < 20000);
		if (q[0] !== 1'b0)
			n_mismatch++;
	endtask
	task wait_got(input int k);
		int n;
		n = 0;
		while (u_crf_tape_model.got.size() < k && n < 3000) begin
			@(posedge clk_sys);
			n++;
		end
		if (u_crf_tape_model.got.size() < k)
			n_mismatch++;
	endtask
	task go(input logic [7:0] st, input logic [15:0] ad, input logic [2:0] cmd);
		wb(1'b1, `CRF_REG_STATUS, {24'h0, st});
		wb(1'b1, `CRF_REG_LENGTH, 32'h2);
		wb(1'b1, `CRF_REG_ADDR, {16'h0, ad});
		wb(1'b1, `CRF_REG_CMD, {29'h0, cmd});
	endtask
	initial begin
		repeat (90000) @(posedge clk_sys);
		n_mismatch++;
		stop_test;
	end
	initial begin
		int n;
		logic [15:0] ck;
		repeat (6) @(posedge clk_sys);
		reset_n <= 1'b1;
		foreach (RA[i]) rd(RA[i], RA[i] == 8'hfc ? 32'h4 : 32'h0);
		wb(1'b1, `CRF_REG_ADDR, 32'h1234);
		sel = 4'h1;
		wb(1'b1, `CRF_REG_ADDR, 32'hffff);
		sel = 4'hf;
		rd(`CRF_REG_ADDR, 32'h12ff);
		wb(1'b1, `CRF_REG_SWITCH, 32'hb2);
		wb(1'b1, 8'h20, 32'h5a);
		rd(`CRF_REG_SWITCH, 32'hb2);
		rd(8'h20, 32'h0);
		mem[8'h10] = 8'h41;
		mem[8'h11] = 8'hc0;
		for (int f = 0; f < 2; f++) begin
			u_crf_tape_model.got.delete();
			pl.delete();
			if (f == 0) begin
				repeat (32) pl.push_back(8'h16);
				pl.push_back(8'h02);
				pl.push_back(8'h02);
			end
			pl.push_back(8'h41);
			pl.push_back(8'hc0);
			if (f == 0) begin
				pl.push_back(8'h03);
				pl.push_back(8'h00);
				pl.push_back(8'h02);
			end
			go(f == 0 ? 8'h80 : 8'h00, 16'h1210, 3'h1);
			idle;
			repeat (FR) @(posedge clk_sys);
			check(u_crf_tape_model.got.size(), pl.size());
			foreach (pl[i]) check(u_crf_tape_model.got[i], pl[i]);
			check(u_crf_tape_model.stop_bad, 0);
			rd(`CRF_REG_RESULT, 32'h0);
		end
		for (int k = 0; k < 7; k++) begin
			pl.delete();
			mem[8'h40] = 8'h00;
			ck = 16'h00ff + {15'h0, k == 5};
			repeat (NS[k]) pl.push_back(8'h16);
			pl.push_back(SX[k]);
			pl.push_back(LN[k][7:0]);
			for (int i = 0; i < LN[k]; i++) begin
				pl.push_back(8'hf0 + i[7:0]);
				ck = ck + {8'h0, 8'hf0 + i[7:0]};
			end
			pl.push_back(EX[k]);
			pl.push_back(ck[7:0]);
			pl.push_back(ck[15:8]);
			go(8'h81, 16'h0040, 3'h1);
			if (NS[k] != 0)
				u_crf_tape_model.play(pl);
			idle;
			rd(`CRF_REG_RESULT, {21'h0, EC[k], 6'h0, EC[k] != 3'h0, 1'b0});
			if (EC[k] == 3'h0 || EC[k] == 3'h5)
				check(mem[8'h40], EC[k] == 3'h0 ? 8'hf0 : 8'h00);
		end
		wb(1'b1, `CRF_REG_SWITCH, 32'h10);
		wb(1'b1, `CRF_REG_CMD, 32'h2);
		idle;
		rd(`CRF_REG_RESULT, 32'h0);
		rd(`CRF_REG_LAMP, 32'h0);
		wb(1'b1, `CRF_REG_SWITCH, 32'h31);
		u_crf_tape_model.got.delete();
		wb(1'b1, `CRF_REG_CMD, 32'h2);
		rd(`CRF_REG_LAMP, 32'h30);
		wait_got(1);
		check(u_crf_tape_model.got[0], 8'haa);
		wb(1'b1, `CRF_REG_CMD, 32'h3);
		idle;
		rd(`CRF_REG_RESULT, 32'h102);
		n = 0;
		do begin
			wb(1'b0, `CRF_REG_LAMP, 32'h0);
			n++;
		end while (q == 32'h0 && n < 100);
		check(q, 32'h1);
		u_crf_tape_model.got.delete();
		wb(1'b1, `CRF_REG_CMD, 32'h4);
		wait_got(2);
		wb(1'b1, `CRF_REG_CMD, 32'h0);
		check(u_crf_tape_model.got[0], 8'haa);
		check(u_crf_tape_model.got[1], 8'haa);
		wb(1'b1, `CRF_REG_CMD, 32'h5);
		pl.delete();
		pl.push_back(8'haa);
		u_crf_tape_model.play(pl);
		rd(`CRF_REG_LAMP, 32'haa);
		wb(1'b1, `CRF_REG_CMD, 32'h0);
		stop_test;
	end
endmodule // crf_record_framer_tb
